// file: verilog/e0ts_pkg.sv
// constants for the endpoint 0 transmit status and fifo flag block
package e0ts_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] ADDR_CTL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    // outcome status fields
    localparam int ST_TOGGLE = 7;
    localparam int ST_STAGE = 4;
    localparam int ST_STALL = 3;
    localparam int ST_NAK = 2;
    localparam int ST_ERROR = 1;
    localparam int ST_ACK = 0;
    // fifo condition fields
    localparam int FL_EMPTY = 3;
    localparam int FL_FULL = 2;
    localparam int FL_UNDER = 1;
    localparam int FL_OVER = 0;
    // control fields
    localparam int CT_CLEAR = 7;
    localparam int CT_STALL = 3;
    localparam int CT_SEND = 1;
    // fifo geometry
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam logic [3:0] FIFO_FULL_CNT = 4'h8;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verilog/e0ts_top.sv
// endpoint 0 transmit status, fifo flags and axi4-lite register slave
// Behaviour
// - successful setup stage sets data toggle
// - toggle inverts after each acked data stage
// - toggle selects DATA0 or DATA1 pid
// - status stage flag set; cleared at setup
// - stall status set/refreshed at in end
// - stall control forces stall answer automatically
// - nak status set/refreshed at in end
// - nak answered when no packet ready
// - error status set/refreshed at in end
// - host ack sets ack bit and interrupt
// - ack cleared by software or next setup
// - reset clears all but fifo storage, sets fifo empty
// - empty flag tracks fifo holding nothing
// - full flag tracks fifo full
// - read from empty fifo sets under-run
// - write into full fifo sets over-run
// - clear control recovers, drops flags; interrupt stays while ack set
// - clear resets pointers, flags, then self-clears
// - count write enables send; ack disables
`timescale 1ns/10ps
module e0ts_top (
    input wire logic clk_sys,
    input wire logic rst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // link engine events, one-cycle pulses; inHostAck and inError are levels read only with inDone
    input wire logic setupBegin,
    input wire logic setupDone,
    input wire logic statusStageSeen,
    input wire logic inStart,
    input wire logic txPop,
    input wire logic inDone,
    input wire logic inHostAck,
    input wire logic inError,
    // link engine answers
    output logic respStall,
    output logic respNak,
    output logic respData,
    output logic dataPidOne,
    output logic [7:0] txByte,
    output logic epTxIrq
);
    // status and control state
    logic txDataToggle_reg;
    logic statusStageSeen_reg;
    logic stallSt_reg;
    logic nakSt_reg;
    logic errorSt_reg;
    logic ackSt_reg;
    logic fifoUnderrunFlag_reg;
    logic fifoOverrunFlag_reg;
    logic txFifoClearCtl_reg;
    logic txStallRequest_reg;
    logic txFifoSendEnable_reg;
    logic [3:0] byteCount_reg;
    logic respStall_reg;
    logic respNak_reg;
    logic respData_reg;
    logic [7:0] txByte_reg;
    // fifo storage
    logic [7:0] fifoMem [e0ts_pkg::FIFO_DEPTH];
    logic [e0ts_pkg::PTR_W-1:0] wrPtr_reg;
    logic [e0ts_pkg::PTR_W-1:0] rdPtr_reg;
    logic [3:0] fill_reg;
    // bus state
    logic bValid_reg;
    logic [1:0] bResp_reg;
    logic rValid_reg;
    logic [1:0] rResp_reg;
    logic [31:0] rData_reg;

    logic fifoEmpty;
    logic fifoFull;
    logic wrTake;
    logic wrLow;
    logic wrCtl;
    logic wrStatus;
    logic wrCount;
    logic wrData;
    logic wrMapped;
    logic rdTake;
    logic pushOk;
    logic popOk;
    logic ackSet;
    logic [7:0] statusByte;
    logic [7:0] flagsByte;
    logic [7:0] ctlByte;

    assign fifoEmpty = (fill_reg == 4'h0);
    assign fifoFull = (fill_reg == e0ts_pkg::FIFO_FULL_CNT);

    // write address and data are taken together, one at a time
    assign wrTake = s_axi_awvalid & s_axi_wvalid & ~bValid_reg;
    assign s_axi_awready = wrTake;
    assign s_axi_wready = wrTake;
    assign wrLow = wrTake & s_axi_wstrb[0];
    assign wrCtl = wrLow & (s_axi_awaddr == e0ts_pkg::ADDR_CTL);
    assign wrStatus = wrLow & (s_axi_awaddr == e0ts_pkg::ADDR_STATUS);
    assign wrCount = wrLow & (s_axi_awaddr == e0ts_pkg::ADDR_COUNT);
    assign wrData = wrLow & (s_axi_awaddr == e0ts_pkg::ADDR_DATA);
    assign wrMapped = (s_axi_awaddr == e0ts_pkg::ADDR_CTL) |
                      (s_axi_awaddr == e0ts_pkg::ADDR_STATUS) |
                      (s_axi_awaddr == e0ts_pkg::ADDR_FLAGS) |
                      (s_axi_awaddr == e0ts_pkg::ADDR_COUNT) |
                      (s_axi_awaddr == e0ts_pkg::ADDR_DATA);
    assign rdTake = s_axi_arvalid & ~rValid_reg;
    assign s_axi_arready = ~rValid_reg;

    // a clear in progress freezes fifo traffic for its one cycle
    assign pushOk = wrData & ~fifoFull & ~txFifoClearCtl_reg;
    assign popOk = txPop & ~fifoEmpty & ~txFifoClearCtl_reg;
    // ack only counts when data went out and the host acked cleanly
    assign ackSet = inDone & respData_reg & inHostAck & ~inError;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bValid_reg <= 1'b0;
            bResp_reg <= e0ts_pkg::RESP_OKAY;
        end else if (wrTake) begin
            bValid_reg <= 1'b1;
            bResp_reg <= wrMapped ? e0ts_pkg::RESP_OKAY :
                         e0ts_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;

    always_comb begin
        statusByte = 8'h00;
        statusByte[e0ts_pkg::ST_TOGGLE] = txDataToggle_reg;
        statusByte[e0ts_pkg::ST_STAGE] = statusStageSeen_reg;
        statusByte[e0ts_pkg::ST_STALL] = stallSt_reg;
        statusByte[e0ts_pkg::ST_NAK] = nakSt_reg;
        statusByte[e0ts_pkg::ST_ERROR] = errorSt_reg;
        statusByte[e0ts_pkg::ST_ACK] = ackSt_reg;
        flagsByte = 8'h00;
        flagsByte[e0ts_pkg::FL_EMPTY] = fifoEmpty;
        flagsByte[e0ts_pkg::FL_FULL] = fifoFull;
        flagsByte[e0ts_pkg::FL_UNDER] = fifoUnderrunFlag_reg;
        flagsByte[e0ts_pkg::FL_OVER] = fifoOverrunFlag_reg;
        ctlByte = 8'h00;
        ctlByte[e0ts_pkg::CT_CLEAR] = txFifoClearCtl_reg;
        ctlByte[e0ts_pkg::CT_STALL] = txStallRequest_reg;
        ctlByte[e0ts_pkg::CT_SEND] = txFifoSendEnable_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rValid_reg <= 1'b0;
            rResp_reg <= e0ts_pkg::RESP_OKAY;
            rData_reg <= 32'h0000_0000;
        end else if (rdTake) begin
            rValid_reg <= 1'b1;
            rResp_reg <= e0ts_pkg::RESP_OKAY;
            case (s_axi_araddr)
                e0ts_pkg::ADDR_CTL: rData_reg <= {24'h000000, ctlByte};
                e0ts_pkg::ADDR_STATUS: rData_reg <= {24'h000000, statusByte};
                e0ts_pkg::ADDR_FLAGS: rData_reg <= {24'h000000, flagsByte};
                e0ts_pkg::ADDR_COUNT: rData_reg <= {28'h0000000,
                                                    byteCount_reg};
                // fifo data is write only
                e0ts_pkg::ADDR_DATA: rData_reg <= 32'h0000_0000;
                default: begin
                    rData_reg <= 32'h0000_0000;
                    rResp_reg <= e0ts_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;

    // fifo pointers and fill level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wrPtr_reg <= 3'h0;
            rdPtr_reg <= 3'h0;
            fill_reg <= 4'h0;
        end else if (txFifoClearCtl_reg) begin
            wrPtr_reg <= 3'h0;
            rdPtr_reg <= 3'h0;
            fill_reg <= 4'h0;
        end else begin
            if (pushOk) begin
                wrPtr_reg <= wrPtr_reg + 3'h1;
            end
            if (popOk) begin
                rdPtr_reg <= rdPtr_reg + 3'h1;
            end
            if (pushOk & ~popOk) begin
                fill_reg <= fill_reg + 4'h1;
            end else if (popOk & ~pushOk) begin
                fill_reg <= fill_reg - 4'h1;
            end
        end
    end

    // storage has no reset; contents are meaningless until written
    always_ff @(posedge clk_sys) begin
        if (pushOk) begin
            fifoMem[wrPtr_reg] <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txByte_reg <= 8'h00;
        end else if (popOk) begin
            txByte_reg <= fifoMem[rdPtr_reg];
        end
    end
    assign txByte = txByte_reg;

    // under-run and over-run stick until the fifo is cleared
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fifoUnderrunFlag_reg <= 1'b0;
            fifoOverrunFlag_reg <= 1'b0;
        end else if (txFifoClearCtl_reg) begin
            fifoUnderrunFlag_reg <= 1'b0;
            fifoOverrunFlag_reg <= 1'b0;
        end else begin
            if (txPop & fifoEmpty) begin
                fifoUnderrunFlag_reg <= 1'b1;
            end
            if (wrData & fifoFull) begin
                fifoOverrunFlag_reg <= 1'b1;
            end
        end
    end

    // clear control: set by software, acts once, then drops itself
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txFifoClearCtl_reg <= 1'b0;
        end else if (wrCtl & s_axi_wdata[e0ts_pkg::CT_CLEAR]) begin
            txFifoClearCtl_reg <= 1'b1;
        end else begin
            txFifoClearCtl_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txStallRequest_reg <= 1'b0;
        end else if (setupDone) begin
            txStallRequest_reg <= 1'b0;
        end else if (wrCtl) begin
            txStallRequest_reg <= s_axi_wdata[e0ts_pkg::CT_STALL];
        end
    end

    // send enable; a count write in the same cycle as a drop wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txFifoSendEnable_reg <= 1'b0;
        end else if (wrCount) begin
            txFifoSendEnable_reg <= 1'b1;
        end else if (ackSet | setupDone | txFifoClearCtl_reg) begin
            txFifoSendEnable_reg <= 1'b0;
        end else if (wrCtl) begin
            txFifoSendEnable_reg <= s_axi_wdata[e0ts_pkg::CT_SEND];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            byteCount_reg <= 4'h0;
        end else if (wrCount) begin
            byteCount_reg <= s_axi_wdata[3:0];
        end
    end

    // answer chosen at the token and held through the transaction
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            respStall_reg <= 1'b0;
            respNak_reg <= 1'b0;
            respData_reg <= 1'b0;
        end else if (inStart) begin
            respStall_reg <= txStallRequest_reg;
            respNak_reg <= ~txStallRequest_reg & ~txFifoSendEnable_reg;
            respData_reg <= ~txStallRequest_reg & txFifoSendEnable_reg;
        end else if (inDone) begin
            respStall_reg <= 1'b0;
            respNak_reg <= 1'b0;
            respData_reg <= 1'b0;
        end
    end
    assign respStall = respStall_reg;
    assign respNak = respNak_reg;
    assign respData = respData_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txDataToggle_reg <= 1'b0;
        end else if (setupDone) begin
            txDataToggle_reg <= 1'b1;
        end else if (ackSet) begin
            txDataToggle_reg <= ~txDataToggle_reg;
        end
    end
    assign dataPidOne = txDataToggle_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            statusStageSeen_reg <= 1'b0;
        end else if (statusStageSeen) begin
            statusStageSeen_reg <= 1'b1;
        end else if (setupBegin) begin
            statusStageSeen_reg <= 1'b0;
        end
    end

    // outcome bits refresh at the end of every in transaction
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stallSt_reg <= 1'b0;
            nakSt_reg <= 1'b0;
            errorSt_reg <= 1'b0;
        end else if (inDone) begin
            stallSt_reg <= respStall_reg;
            nakSt_reg <= respNak_reg;
            errorSt_reg <= inError;
        end
    end

    // hardware set beats a software or setup clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ackSt_reg <= 1'b0;
        end else if (ackSet) begin
            ackSt_reg <= 1'b1;
        end else if (setupBegin) begin
            ackSt_reg <= 1'b0;
        end else if (wrStatus & ~s_axi_wdata[e0ts_pkg::ST_ACK]) begin
            ackSt_reg <= 1'b0;
        end
    end

    assign epTxIrq = ackSt_reg | fifoUnderrunFlag_reg |
                     fifoOverrunFlag_reg;
endmodule

// file: verification/e0ts_top_asserts.sv
// port checks for the endpoint 0 transmit status block
`timescale 1ns/10ps
module e0ts_top_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic setupDone,
    input wire logic inStart,
    input wire logic inDone,
    input wire logic inHostAck,
    input wire logic inError,
    input wire logic respStall,
    input wire logic respNak,
    input wire logic respData,
    input wire logic dataPidOne,
    input wire logic epTxIrq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic okIn;
    // only a clean acked data packet counts as success
    assign okIn = inDone && respData && inHostAck && !inError;
    irq_on_ack_a: assert property (okIn |=> epTxIrq)
        else $error("ack did not raise the irq");
    toggle_flip_a: assert property (okIn && !setupDone |=>
        dataPidOne != $past(dataPidOne)) else $error("toggle kept");
    toggle_set_a: assert property (setupDone && !inDone |=>
        dataPidOne) else $error("toggle not set by setup");
    one_answer_a: assert property (inStart |=>
        $onehot({respStall, respNak, respData})) else $error("answer");
    answer_end_a: assert property (inDone && !inStart |=>
        !(respStall || respNak || respData)) else $error("answer held");
    write_resp_a: assert property (s_axi_awvalid && s_axi_wvalid &&
        !s_axi_bvalid |=> s_axi_bvalid) else $error("no write response");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("no read response");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
endmodule

// file: verification/e0ts_host_model.sv
// link-side model issuing setup and in transaction events
`timescale 1ns/10ps
module e0ts_host_model (
    input wire logic clk_sys,
    output wire logic setupBegin,
    output wire logic setupDone,
    output wire logic statusStageSeen,
    output wire logic inStart,
    output wire logic txPop,
    output logic inDone,
    output logic inHostAck,
    output logic inError
);
    logic [4:0] ev = 5'h00;
    assign {txPop, inStart, statusStageSeen, setupDone, setupBegin} = ev;
    initial begin
        inDone = 1'h0;
        inHostAck = 1'h1;
        inError = 1'h1;
    end
    task pulse(input logic [4:0] m);
        @(posedge clk_sys);
        ev <= m;
        @(posedge clk_sys);
        ev <= 5'h00;
    endtask
    // levels only mean something at inDone, so they invert afterwards
    task done(input logic a, input logic e);
        @(posedge clk_sys);
        inDone <= 1'h1;
        inHostAck <= a;
        inError <= e;
        @(posedge clk_sys);
        inDone <= 1'h0;
        inHostAck <= !a;
        inError <= !e;
    endtask
endmodule

// file: verification/e0ts_top_tb.sv
// self-checking bench for the endpoint 0 transmit status block
`timescale 1ns/10ps
module e0ts_top_tb;
    logic clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, setupBegin;
    logic setupDone, statusStageSeen, inStart, txPop, inDone, inHostAck;
    logic inError, respStall, respNak, respData, dataPidOne, epTxIrq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, txByte, d;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    logic [31:0] seed = 32'h00008fb5;
    logic [7:0] q[$];
    bit tog, stg, stl, nak, err, ack, und, ovr, sen, stc;
    localparam logic [4:0] SB = 5'h01, SD = 5'h02, SS = 5'h04;
    localparam logic [4:0] IS = 5'h08, TP = 5'h10;
    e0ts_top uut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .setupBegin,
        .setupDone, .statusStageSeen, .inStart, .txPop, .inDone,
        .inHostAck, .inError, .respStall, .respNak, .respData,
        .dataPidOne, .txByte, .epTxIrq);
    e0ts_host_model host (.clk_sys, .setupBegin, .setupDone,
        .statusStageSeen, .inStart, .txPop, .inDone, .inHostAck, .inError);
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [31:0] st();
        return {24'h0, tog, 2'h0, stg, stl, nak, err, ack};
    endfunction
    function automatic logic [31:0] fl();
        return {28'h0, q.size() == 0, q.size() == 8, und, ovr};
    endfunction
    // control readback: clear always reads back as dropped
    function automatic logic [31:0] ct();
        return {28'h0, stc, 1'h0, sen, 1'h0};
    endfunction
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t value %h want %h", $time, g, e);
        end
    endtask
    task chk_pin(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t pin %b want %b", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        logic [1:0] br;
        br = (a == e0ts_pkg::ADDR_CTL || a == e0ts_pkg::ADDR_STATUS ||
              a == e0ts_pkg::ADDR_FLAGS || a == e0ts_pkg::ADDR_COUNT ||
              a == e0ts_pkg::ADDR_DATA) ? e0ts_pkg::RESP_OKAY :
             e0ts_pkg::RESP_SLVERR;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do @(posedge clk_sys); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        @(posedge clk_sys);
        s_axi_bready <= 1'h1;
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk_reg({30'h0, s_axi_bresp}, {30'h0, br});
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        logic [31:0] g;
        logic [1:0] gr;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        @(posedge clk_sys);
        s_axi_rready <= 1'h1;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
        g = s_axi_rdata;
        gr = s_axi_rresp;
        s_axi_rready <= 1'h0;
        chk_reg(g, e);
        chk_reg({30'h0, gr}, {30'h0, r});
    endtask
    task fill(input logic [7:0] n);
        repeat (n) begin
            d = xorshift();
            wr(e0ts_pkg::ADDR_DATA, d);
            q.push_back(d);
        end
        wr(e0ts_pkg::ADDR_COUNT, n);
        sen = 1;
    endtask
    task run_in(input int n, input logic a, input logic e);
        chk_pin(dataPidOne, tog);
        host.pulse(IS);
        #1;
        chk_pin(respStall, stc);
        chk_pin(respNak, !stc && !sen);
        chk_pin(respData, !stc && sen);
        repeat (n) begin
            host.pulse(TP);
            #1;
            if (q.size() == 0) und = 1;
            else chk_reg({24'h0, txByte}, {24'h0, q.pop_front()});
        end
        host.done(a, e);
        stl = stc;
        nak = !stc && !sen;
        err = e;
        if (!stc && sen && a && !e) begin
            ack = 1;
            tog = !tog;
            sen = 0;
        end
        #1 chk_pin(epTxIrq, ack || und || ovr);
        rdc(e0ts_pkg::ADDR_STATUS, st(), e0ts_pkg::RESP_OKAY);
        rdc(e0ts_pkg::ADDR_FLAGS, fl(), e0ts_pkg::RESP_OKAY);
    endtask
    // clearing empties the fifo, so the model queue goes too
    task clr;
        wr(e0ts_pkg::ADDR_CTL, 8'h80);
        q.delete();
        und = 0;
        ovr = 0;
        stc = 0;
        sen = 0;
        rdc(e0ts_pkg::ADDR_FLAGS, fl(), e0ts_pkg::RESP_OKAY);
        rdc(e0ts_pkg::ADDR_CTL, ct(), e0ts_pkg::RESP_OKAY);
        #1 chk_pin(epTxIrq, ack);
    endtask
    task end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    initial begin
        rst = 1'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'h1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        rdc(e0ts_pkg::ADDR_FLAGS, fl(), e0ts_pkg::RESP_OKAY);
        rdc(e0ts_pkg::ADDR_STATUS, st(), e0ts_pkg::RESP_OKAY);
        rdc(8'h40, 32'h0, e0ts_pkg::RESP_SLVERR);
        wr(8'h40, 8'hff);
        for (int i = 0; i < 9; i++) begin
            d = xorshift();
            wr(e0ts_pkg::ADDR_DATA, d);
            if (q.size() < 8) q.push_back(d);
            else ovr = 1;
            if (i == 7) rdc(e0ts_pkg::ADDR_FLAGS, fl(), 2'h0);
        end
        rdc(e0ts_pkg::ADDR_FLAGS, fl(), e0ts_pkg::RESP_OKAY);
        #1 chk_pin(epTxIrq, 1'h1);
        clr;
        host.pulse(SD);
        tog = 1;
        rdc(e0ts_pkg::ADDR_STATUS, st(), e0ts_pkg::RESP_OKAY);
        run_in(0, 1'h1, 1'h0);
        fill(8'h02);
        rdc(e0ts_pkg::ADDR_CTL, ct(), e0ts_pkg::RESP_OKAY);
        run_in(2, 1'h1, 1'h0);
        rdc(e0ts_pkg::ADDR_CTL, ct(), e0ts_pkg::RESP_OKAY);
        wr(e0ts_pkg::ADDR_STATUS, 8'h00);
        ack = 0;
        #1 chk_pin(epTxIrq, 1'h0);
        wr(e0ts_pkg::ADDR_CTL, 8'h08);
        stc = 1;
        sen = 0;
        run_in(0, 1'h0, 1'h1);
        wr(e0ts_pkg::ADDR_CTL, 8'h00);
        stc = 0;
        fill(8'h01);
        run_in(1, 1'h1, 1'h0);
        host.pulse(SS);
        stg = 1;
        rdc(e0ts_pkg::ADDR_STATUS, st(), e0ts_pkg::RESP_OKAY);
        host.pulse(SB);
        stg = 0;
        ack = 0;
        rdc(e0ts_pkg::ADDR_STATUS, st(), e0ts_pkg::RESP_OKAY);
        fill(8'h01);
        run_in(2, 1'h0, 1'h1);
        clr;
        end_of_test;
    end
endmodule
bind e0ts_top e0ts_top_asserts chk (.clk_sys, .rst, .s_axi_awvalid,
    .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .setupDone, .inStart, .inDone, .inHostAck, .inError,
    .respStall, .respNak, .respData, .dataPidOne, .epTxIrq);
